// ===== include/ptc_defines.svh
// Register offsets, reset values and timing counts for the pulse counter
//
// Overview of operation
// - Count only while start control holds 1
// - Clear request 1 clears counts, 0 keeps
// - Store per-cycle sample count, 0 to 32767
// - Running sum 0 to 99999999, two words
// - Sample equals pulses times prescale times factor; scale selection 0 gives raw pulses
// - Prescale settable 0 to 32767, resets to 1
// - Pulse input only for selection 1,11,21,100
// - Selections 10,11,20,21,100 need meter variant
`ifndef PTC_DEFINES_SVH
`define PTC_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PTC_OFF_SAMPLE     8'h00
`define PTC_OFF_CUM_LO     8'h04
`define PTC_OFF_CUM_HI     8'h08
`define PTC_OFF_CLEAR      8'h0c
`define PTC_OFF_START      8'h10
`define PTC_OFF_TIO_SEL    8'h14
`define PTC_OFF_SCALE_SEL  8'h18
`define PTC_OFF_PRESCALE   8'h1c
`define PTC_OFF_IN_DIV     8'h20
`define PTC_OFF_STATUS     8'h24

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define PTC_RST_PRESCALE   16'h0001
`define PTC_MAX_SAMPLE     32'h0000_7fff
`define PTC_MAX_CUM        27'h5f5_e0ff
`define PTC_CUM_MODULUS    28'h5f5_e100
`define PTC_MAX_SCALE_SEL  16'h0005

// ****************************************************************
// Timing: count cycle length
// ****************************************************************
`define PTC_CLK_PERIOD_NS  5
`define PTC_CYCLE_TIME_NS  1000000
`define PTC_CYCLE_CLKS     (`PTC_CYCLE_TIME_NS / `PTC_CLK_PERIOD_NS)

`endif

// ===== include/ptc_pkg.sv
// Types shared by the pulse train input counter
package ptc_pkg;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ptc_apb_req_s;

    // APB answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ptc_apb_rsp_s;

    // Count cycle sequencer; each step except HOLD to IDLE changes one bit
    typedef enum logic [1:0] {
        PTC_ST_IDLE  = 2'b00,
        PTC_ST_COUNT = 2'b01,
        PTC_ST_HOLD  = 2'b11
    } ptc_state_e;

endpackage

// ===== testbench/ptc_checker.sv
// Concurrent checks on the pulse counter ports
`timescale 1ns/10ps
`include "ptc_defines.svh"

module ptc_checker
    import ptc_pkg::*;
(
    input wire logic         i_clk_sys,    // System clock
    input wire logic         i_rst,        // Async reset
    input wire ptc_apb_req_s i_apb,        // APB request
    input wire ptc_apb_rsp_s o_apb,        // APB answer
    input wire logic         i_pulse_in,   // Terminal level
    input wire logic         o_term_lvl,   // Ordinary level
    input wire logic         o_pulse_mode  // Pulse mode flag
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    // Waiting access phases and reads of a given place
    wire logic       acc  = i_apb.psel && i_apb.penable && !o_apb.pready;
    wire logic       wacc = acc && i_apb.pwrite;
    wire logic       rdy  = o_apb.pready && !i_apb.pwrite;
    wire logic [7:0] ad   = i_apb.paddr;
    wire logic [31:0] wd  = i_apb.pwdata;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    one_wait_a: assert property (acc |=> o_apb.pready)
        else $error("answer did not come after one wait");
    scale_refuse_a: assert property (
        wacc && ad == `PTC_OFF_SCALE_SEL && wd > 32'd5
        |=> o_apb.pready && o_apb.pslverr) else $error("bad scale taken");
    pre_refuse_a: assert property (
        wacc && ad == `PTC_OFF_PRESCALE && wd[15]
        |=> o_apb.pslverr) else $error("bad prescale taken");
    tio_refuse_a: assert property (
        wacc && ad == `PTC_OFF_TIO_SEL &&
        !(wd inside {32'd0, 32'd1, 32'd10, 32'd11, 32'd20, 32'd21, 32'd100})
        |=> o_apb.pslverr) else $error("bad selection taken");
    term_copy_a: assert property (
        !o_pulse_mode && $past(!o_pulse_mode)
        |-> o_term_lvl == $past(i_pulse_in)) else $error("level not copied");
    term_quiet_a: assert property (
        o_pulse_mode && $past(o_pulse_mode) |-> !o_term_lvl)
        else $error("level shown in pulse mode");
    sample_range_a: assert property (
        rdy && ad == `PTC_OFF_SAMPLE |-> o_apb.prdata <= `PTC_MAX_SAMPLE)
        else $error("sample out of range");
    cum_range_a: assert property (
        rdy && ad == `PTC_OFF_CUM_HI |-> o_apb.prdata <= 32'h0000_05f5)
        else $error("cumulative high out of range");
    pre_range_a: assert property (
        rdy && ad == `PTC_OFF_PRESCALE |-> o_apb.prdata <= 32'h0000_7fff)
        else $error("prescale out of range");

    // Main scenarios reached
    cover property (o_apb.pslverr);
    cover property (o_pulse_mode && i_pulse_in);
    cover property (rdy && ad == `PTC_OFF_SAMPLE && o_apb.prdata != 0);
endmodule

bind ptc_pulse_counter ptc_checker u_ptc_checker (
    .i_clk_sys    (i_clk_sys),
    .i_rst        (i_rst),
    .i_apb        (i_apb),
    .o_apb        (o_apb),
    .i_pulse_in   (i_pulse_in),
    .o_term_lvl   (o_term_lvl),
    .o_pulse_mode (o_pulse_mode)
);

// ===== testbench/ptc_pulse_src.sv
// External pulse train source for the input terminal
`timescale 1ns/10ps

module ptc_pulse_src (
    input  wire logic       i_clk_sys, // System clock
    input  wire logic       i_rst,     // Async reset
    input  wire logic [7:0] i_count,   // Pulses in a burst
    input  wire logic       i_go,      // Start a burst
    output logic            o_pulse    // Pulse line, idle low
);
    logic [8:0] cnt_ff;
    logic [8:0] nxt_cnt;

    // One high and one low cycle per pulse, so every edge is seen
    always_comb begin
        nxt_cnt = cnt_ff;
        if (i_go) begin
            nxt_cnt = {i_count, 1'b0};
        end else if (cnt_ff != 9'h000) begin
            nxt_cnt = cnt_ff - 9'h001;
        end
    end

    // Burst counter
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= 9'h000;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign o_pulse = cnt_ff[0];
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the pulse train input counter
`timescale 1ns/10ps
`include "ptc_defines.svh"

module testbench;
    import ptc_pkg::*;

    // Short count cycle keeps the run brief
    localparam int CYC = 200;
    typedef struct packed {
        logic [15:0] tio;
        logic [15:0] scl;
        logic [15:0] pre;
        logic [7:0]  n;
        logic [15:0] smp;
        logic        md;
    } ptc_row_s;

    logic         i_clk_sys = 1'b0;
    logic         i_rst     = 1'b1;
    ptc_apb_req_s req       = '0;
    ptc_apb_rsp_s rsp;
    logic         pulse;
    logic         pulse_mode;
    logic         term_lvl;
    logic [7:0]   src_n     = 8'h00;
    logic         src_go    = 1'b0;
    logic [31:0]  rd;
    int           errors          = 0;
    int           samples_checked = 0;
    // Selection, scale, prescale, pulses -> sample, mode
    ptc_row_s rows [10] = '{
        '{16'd1, 16'd0, 16'd7, 8'd5, 16'd5, 1'b1},
        '{16'd11, 16'd1, 16'd3, 8'd4, 16'd12, 1'b1},
        '{16'd21, 16'd2, 16'd20, 8'd5, 16'd10, 1'b1},
        '{16'd100, 16'd3, 16'd100, 8'd3, 16'd3, 1'b1},
        '{16'd1, 16'd4, 16'd1000, 8'd2, 16'd2, 1'b1},
        '{16'd1, 16'd5, 16'd10000, 8'd3, 16'd3, 1'b1},
        '{16'd1, 16'd1, 16'd32767, 8'd2, 16'd32767, 1'b1},
        '{16'd0, 16'd1, 16'd1, 8'd5, 16'd0, 1'b0},
        '{16'd10, 16'd1, 16'd1, 8'd5, 16'd0, 1'b0},
        '{16'd20, 16'd1, 16'd1, 8'd5, 16'd0, 1'b0}};

    always #2.5 i_clk_sys = ~i_clk_sys;

    ptc_pulse_counter #(.CYCLE_CLKS(CYC)) u_ptc_pulse_counter (
        .i_clk_sys    (i_clk_sys),
        .i_rst        (i_rst),
        .i_apb        (req),
        .o_apb        (rsp),
        .i_pulse_in   (pulse),
        .o_term_lvl   (term_lvl),
        .o_pulse_mode (pulse_mode)
    );

    ptc_pulse_src u_ptc_pulse_src (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_count   (src_n),
        .i_go      (src_go),
        .o_pulse   (pulse)
    );

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One APB transfer; read data and error taken at the ready edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic err);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge i_clk_sys);
        req.penable <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (rsp.pready !== 1'b1 && n < 8);
        rd = rsp.prdata;
        check(32'(rsp.pslverr), 32'(err));
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        if (n >= 8) begin
            errors++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b0);
        check(rd, exp);
    endtask

    task automatic burst(input logic [7:0] n);
        src_n  <= n;
        src_go <= 1'b1;
        @(posedge i_clk_sys);
        src_go <= 1'b0;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        wr(`PTC_OFF_IN_DIV, 32'h0);
        for (int a = 0; a < 8; a++) begin
            rchk(8'(a * 4), (a == 7) ? 32'h1 : 32'h0);
        end
        apb(1'b1, `PTC_OFF_SCALE_SEL, 32'h6, 1'b1);
        apb(1'b1, `PTC_OFF_TIO_SEL, 32'h2, 1'b1);
        apb(1'b1, `PTC_OFF_PRESCALE, 32'h8000, 1'b1);
        apb(1'b1, `PTC_OFF_START, 32'h1_0001, 1'b1);
        apb(1'b0, 8'h28, 32'h0, 1'b1);
        check(rd, 32'h0);
        rchk(`PTC_OFF_SCALE_SEL, 32'h0);
        rchk(`PTC_OFF_PRESCALE, 32'h1);
        rchk(`PTC_OFF_START, 32'h0);
        // Read between first and second boundary of the count
        for (int i = 0; i < 10; i++) begin
            wr(`PTC_OFF_TIO_SEL, 32'(rows[i].tio));
            wr(`PTC_OFF_SCALE_SEL, 32'(rows[i].scl));
            wr(`PTC_OFF_PRESCALE, 32'(rows[i].pre));
            check(32'(pulse_mode), 32'(rows[i].md));
            wr(`PTC_OFF_START, 32'h1);
            burst(rows[i].n);
            repeat (CYC + CYC / 2) @(posedge i_clk_sys);
            rchk(`PTC_OFF_SAMPLE, 32'(rows[i].smp));
            rchk(`PTC_OFF_CUM_LO, 32'(rows[i].smp));
            rchk(`PTC_OFF_CUM_HI, 32'h0);
            wr(`PTC_OFF_CLEAR, 32'h1);
            rchk(`PTC_OFF_SAMPLE, 32'h0);
            rchk(`PTC_OFF_CUM_LO, 32'h0);
            wr(`PTC_OFF_CLEAR, 32'h0);
            wr(`PTC_OFF_START, 32'h0);
        end
        // Pulses while stopped are not counted
        wr(`PTC_OFF_TIO_SEL, 32'h1);
        burst(8'd5);
        repeat (CYC + CYC / 2) @(posedge i_clk_sys);
        rchk(`PTC_OFF_CUM_LO, 32'h0);
        // Saturated sample flags overflow; software then lowers the gain
        wr(`PTC_OFF_PRESCALE, 32'h7fff);
        wr(`PTC_OFF_START, 32'h1);
        burst(8'd2);
        repeat (CYC + CYC / 2) @(posedge i_clk_sys);
        rchk(`PTC_OFF_STATUS, 32'h7);
        wr(`PTC_OFF_SCALE_SEL, 32'h2);
        burst(8'd2);
        repeat (CYC) @(posedge i_clk_sys);
        rchk(`PTC_OFF_SAMPLE, 32'h1999);
        rchk(`PTC_OFF_STATUS, 32'h3);
        wr(`PTC_OFF_START, 32'h0);
        // Second reset in mid-run restores the prescale
        wr(`PTC_OFF_PRESCALE, 32'h5);
        i_rst <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rchk(`PTC_OFF_PRESCALE, 32'h1);
        // Ordinary terminal mode follows the pin one clock late
        burst(8'd1);
        repeat (3) @(posedge i_clk_sys);
        check(32'(term_lvl), 32'h1);
        @(posedge i_clk_sys);
        check(32'(term_lvl), 32'h0);
        tally_and_finish();
    end
endmodule

// ===== verilog/ptc_pulse_counter.sv
// Pulse train input counter with APB register access
`timescale 1ns/10ps
`include "ptc_defines.svh"

module ptc_pulse_counter
    import ptc_pkg::*;
#(
    parameter int          CYCLE_CLKS = `PTC_CYCLE_CLKS, // Clocks per cycle
    parameter int          PULSE_W    = 16,              // Raw counter width
    parameter bit          HAS_FM     = 1'b1             // Meter variant
) (
    input  wire logic          i_clk_sys,   // 200 MHz system clock
    input  wire logic          i_rst,       // Async reset, active high
    input  wire ptc_apb_req_s  i_apb,       // APB request
    output ptc_apb_rsp_s       o_apb,       // APB answer
    input  wire logic          i_pulse_in,  // Input terminal level
    output logic               o_term_lvl,  // Ordinary terminal level
    output logic               o_pulse_mode // Terminal in pulse mode
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    generate
        if (CYCLE_CLKS < 2) begin : g_bad_cycle
            $error("CYCLE_CLKS must be at least 2");
        end
        if (PULSE_W < 1 || PULSE_W > 16) begin : g_bad_width
            $error("PULSE_W must be 1 to 16");
        end
    endgenerate

    localparam int TW = $clog2(CYCLE_CLKS);
    localparam logic [TW-1:0] TMR_LAST = TW'(CYCLE_CLKS - 1);

    // ************************************************************
    // Register file state
    // ************************************************************
    logic [15:0] clear_ff, nxt_clear;
    logic [15:0] start_ff, nxt_start;
    logic [15:0] tio_ff, nxt_tio;
    logic [15:0] scale_ff, nxt_scale;
    logic [15:0] presc_ff, nxt_presc;
    logic [15:0] indiv_ff, nxt_indiv;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        ready_ff, nxt_ready;
    logic        err_ff, nxt_err;

    // ************************************************************
    // Counting state
    // ************************************************************
    ptc_state_e          st_ff, nxt_st;
    logic [TW-1:0]       tmr_ff, nxt_tmr;
    logic [PULSE_W-1:0]  raw_ff, nxt_raw;
    logic [14:0]         sample_ff, nxt_sample;
    logic [26:0]         cum_ff, nxt_cum;
    logic                ovf_ff, nxt_ovf;
    logic                prev_ff, nxt_prev;
    logic                term_ff, nxt_term;

    logic                acc_phase;
    logic                wr_take;
    logic                addr_ok;
    logic                val_ok;
    logic                pulse_mode;
    logic                counting;
    logic                rise;
    logic                boundary;
    logic [PULSE_W-1:0]  raw_fin;
    logic [31:0]         prod;
    logic [31:0]         scaled;
    logic [14:0]         samp_val;
    logic                samp_ovf;
    logic [27:0]         cum_sum;

    // Selection decode: only these values turn the pin into a counter
    always_comb begin
        pulse_mode = 1'b0;
        case (tio_ff)
            16'd1, 16'd11, 16'd21, 16'd100: pulse_mode = 1'b1;
            default: pulse_mode = 1'b0;
        endcase
    end

    // Write value check per register, refused writes keep old value
    always_comb begin
        val_ok = 1'b1;
        case (i_apb.paddr)
            `PTC_OFF_TIO_SEL: begin
                case (i_apb.pwdata[15:0])
                    16'd0, 16'd1: val_ok = 1'b1;
                    16'd10, 16'd11, 16'd20, 16'd21, 16'd100: begin
                        val_ok = HAS_FM;
                    end
                    default: val_ok = 1'b0;
                endcase
            end
            `PTC_OFF_SCALE_SEL: begin
                val_ok = i_apb.pwdata[15:0] <= `PTC_MAX_SCALE_SEL;
            end
            `PTC_OFF_PRESCALE: begin
                val_ok = ~i_apb.pwdata[15];
            end
            default: val_ok = 1'b1;
        endcase
        if (i_apb.pwdata[31:16] != 16'h0000) begin
            val_ok = 1'b0;
        end
    end

    // Address decode for mapped words
    always_comb begin
        case (i_apb.paddr)
            `PTC_OFF_SAMPLE, `PTC_OFF_CUM_LO, `PTC_OFF_CUM_HI,
            `PTC_OFF_CLEAR, `PTC_OFF_START, `PTC_OFF_TIO_SEL,
            `PTC_OFF_SCALE_SEL, `PTC_OFF_PRESCALE, `PTC_OFF_IN_DIV,
            `PTC_OFF_STATUS: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // APB slave: one wait state so read data comes from a flop
    always_comb begin
        acc_phase = i_apb.psel & i_apb.penable;
        wr_take   = acc_phase & ready_ff & i_apb.pwrite & addr_ok & val_ok;
        nxt_ready = acc_phase & ~ready_ff;
        nxt_err   = err_ff;
        nxt_rdata = rdata_ff;
        nxt_clear = clear_ff;
        nxt_start = start_ff;
        nxt_tio   = tio_ff;
        nxt_scale = scale_ff;
        nxt_presc = presc_ff;
        nxt_indiv = indiv_ff;
        if (acc_phase & ~ready_ff) begin
            nxt_err   = ~addr_ok | (i_apb.pwrite & ~val_ok);
            nxt_rdata = 32'h0000_0000;
            if (!i_apb.pwrite) begin
                case (i_apb.paddr)
                    `PTC_OFF_SAMPLE:    nxt_rdata = {17'h0, sample_ff};
                    `PTC_OFF_CUM_LO:    nxt_rdata = {16'h0, cum_ff[15:0]};
                    `PTC_OFF_CUM_HI:    nxt_rdata = {21'h0, cum_ff[26:16]};
                    `PTC_OFF_CLEAR:     nxt_rdata = {16'h0, clear_ff};
                    `PTC_OFF_START:     nxt_rdata = {16'h0, start_ff};
                    `PTC_OFF_TIO_SEL:   nxt_rdata = {16'h0, tio_ff};
                    `PTC_OFF_SCALE_SEL: nxt_rdata = {16'h0, scale_ff};
                    `PTC_OFF_PRESCALE:  nxt_rdata = {16'h0, presc_ff};
                    `PTC_OFF_IN_DIV:    nxt_rdata = {16'h0, indiv_ff};
                    `PTC_OFF_STATUS: begin
                        nxt_rdata = {29'h0, ovf_ff, counting, pulse_mode};
                    end
                    default: nxt_rdata = 32'h0000_0000;
                endcase
            end
        end
        if (wr_take) begin
            case (i_apb.paddr)
                `PTC_OFF_CLEAR:     nxt_clear = i_apb.pwdata[15:0];
                `PTC_OFF_START:     nxt_start = i_apb.pwdata[15:0];
                `PTC_OFF_TIO_SEL:   nxt_tio   = i_apb.pwdata[15:0];
                `PTC_OFF_SCALE_SEL: nxt_scale = i_apb.pwdata[15:0];
                `PTC_OFF_PRESCALE:  nxt_presc = i_apb.pwdata[15:0];
                `PTC_OFF_IN_DIV:    nxt_indiv = i_apb.pwdata[15:0];
                default: nxt_clear = clear_ff;
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            clear_ff <= 16'h0000;
            start_ff <= 16'h0000;
            tio_ff   <= 16'h0000;
            scale_ff <= 16'h0000;
            presc_ff <= `PTC_RST_PRESCALE;
            indiv_ff <= 16'h0000;
            rdata_ff <= 32'h0000_0000;
            ready_ff <= 1'b0;
            err_ff   <= 1'b0;
        end else begin
            clear_ff <= nxt_clear;
            start_ff <= nxt_start;
            tio_ff   <= nxt_tio;
            scale_ff <= nxt_scale;
            presc_ff <= nxt_presc;
            indiv_ff <= nxt_indiv;
            rdata_ff <= nxt_rdata;
            ready_ff <= nxt_ready;
            err_ff   <= nxt_err;
        end
    end

    // Scaling of the finished cycle; divide by constants only
    always_comb begin
        rise    = i_pulse_in & ~prev_ff;
        raw_fin = raw_ff;
        if (rise && raw_ff != {PULSE_W{1'b1}}) begin
            raw_fin = raw_ff + PULSE_W'(1);
        end
        prod = 32'(raw_fin) * 32'(presc_ff[14:0]);
        case (scale_ff[2:0])
            3'd0:    scaled = 32'(raw_fin);
            3'd1:    scaled = prod;
            3'd2:    scaled = prod / 32'd10;
            3'd3:    scaled = prod / 32'd100;
            3'd4:    scaled = prod / 32'd1000;
            3'd5:    scaled = prod / 32'd10000;
            default: scaled = prod;
        endcase
        // Saturate so software sees overflow rather than a wrapped value
        samp_ovf = scaled > `PTC_MAX_SAMPLE;
        samp_val = samp_ovf ? 15'h7fff : scaled[14:0];
        cum_sum  = {1'b0, cum_ff} + {13'h0, samp_val};
    end

    // Count cycle sequencer and counters
    always_comb begin
        counting   = (st_ff == PTC_ST_COUNT);
        boundary   = counting && (tmr_ff == TMR_LAST);
        nxt_prev   = i_pulse_in;
        nxt_term   = pulse_mode ? 1'b0 : i_pulse_in;
        nxt_st     = st_ff;
        nxt_tmr    = tmr_ff;
        nxt_raw    = raw_ff;
        nxt_sample = sample_ff;
        nxt_cum    = cum_ff;
        nxt_ovf    = ovf_ff;
        case (st_ff)
            PTC_ST_IDLE: begin
                if (start_ff == 16'd1 && pulse_mode) begin
                    nxt_st = PTC_ST_COUNT;
                end
            end
            PTC_ST_COUNT: begin
                if (start_ff != 16'd1 || !pulse_mode) begin
                    nxt_st = PTC_ST_HOLD;
                end else if (boundary) begin
                    // Sample and sum change in the same edge
                    nxt_tmr    = '0;
                    nxt_raw    = '0;
                    nxt_sample = samp_val;
                    nxt_ovf    = samp_ovf;
                    if (cum_sum > {1'b0, `PTC_MAX_CUM}) begin
                        nxt_cum = 27'(cum_sum - `PTC_CUM_MODULUS);
                    end else begin
                        nxt_cum = cum_sum[26:0];
                    end
                end else begin
                    nxt_tmr = tmr_ff + TW'(1);
                    nxt_raw = raw_fin;
                end
            end
            PTC_ST_HOLD: begin
                // Partial cycle is dropped; a restart begins a full cycle
                nxt_tmr = '0;
                nxt_raw = '0;
                nxt_st  = PTC_ST_IDLE;
            end
            default: nxt_st = PTC_ST_IDLE;
        endcase
        if (clear_ff == 16'd1) begin
            nxt_tmr    = '0;
            nxt_raw    = '0;
            nxt_sample = '0;
            nxt_cum    = '0;
            nxt_ovf    = 1'b0;
        end
    end

    // Counting flops
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st_ff     <= PTC_ST_IDLE;
            tmr_ff    <= '0;
            raw_ff    <= '0;
            sample_ff <= '0;
            cum_ff    <= '0;
            ovf_ff    <= 1'b0;
            prev_ff   <= 1'b0;
            term_ff   <= 1'b0;
        end else begin
            st_ff     <= nxt_st;
            tmr_ff    <= nxt_tmr;
            raw_ff    <= nxt_raw;
            sample_ff <= nxt_sample;
            cum_ff    <= nxt_cum;
            ovf_ff    <= nxt_ovf;
            prev_ff   <= nxt_prev;
            term_ff   <= nxt_term;
        end
    end

    // Outputs
    assign o_apb.prdata  = rdata_ff;
    assign o_apb.pready  = ready_ff;
    assign o_apb.pslverr = ready_ff & err_ff;
    assign o_term_lvl    = term_ff;
    assign o_pulse_mode  = pulse_mode;

endmodule
